// File: src/epi_consts.svh
// Register indices, reset values and widths of the external pin interrupt block.
`ifndef EPI_CONSTS_SVH
`define EPI_CONSTS_SVH
// Widths of the bus, the pin groups and the register words.
`define EPI_AW          12
`define EPI_IW          10
`define EPI_N_EXT       3
`define EPI_N_GRP       4
`define EPI_GRP_W       8
`define EPI_N_PC        32
// Register indices; the byte address is four times the index.
`define EPI_IDX_EXT_MSK 10'h01D
`define EPI_IDX_PC_EN   10'h068
`define EPI_IDX_PC_MSK3 10'h073
`define EPI_IDX_PC_MSK2 10'h06D
`define EPI_IDX_PC_MSK1 10'h06C
`define EPI_IDX_PC_MSK0 10'h06B
`define EPI_IDX_SENSE   10'h069
`define EPI_IDX_EXT_FLG 10'h01C
`define EPI_IDX_PC_FLG  10'h01B
// Reset values of the registers.
`define EPI_RST_EXT     3'h0
`define EPI_RST_GRP     4'h0
`define EPI_RST_SENSE   6'h00
`define EPI_RST_PC_MSK  32'h0000_0000
`define EPI_RST_WORD    32'h0000_0000
`endif

// File: src/epi_pkg.sv
// Types shared by the external pin interrupt block.
package epi_pkg;
    // Trigger selected by one two-bit sense field, in field code order.
    typedef enum logic [1:0] {
        EPI_SNS_LOW,
        EPI_SNS_ANY,
        EPI_SNS_FALL,
        EPI_SNS_RISE
    } epi_sense_type;
    // One bit per dedicated pin and one bit per pin-change group.
    typedef logic [2:0] epi_ext_type;
    typedef logic [3:0] epi_grp_type;
    // Whole state of the top module.
    typedef struct packed {
        logic [2:0]  ext_mask;
        logic [5:0]  sense;
        logic [2:0]  ext_flag;
        logic [2:0]  ext_prev;
        logic [3:0]  pc_en;
        logic [31:0] pc_mask;
        logic [3:0]  pc_flag;
        logic [31:0] pc_ref;
        logic [2:0]  ext_irq;
        logic [3:0]  pc_irq;
        logic        wake;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } epi_state_type;
endpackage

// File: src/epi_sync.sv
// Two-stage synchroniser for a vector of pin levels.
`timescale 1ns/1ps
`default_nettype none
module epi_sync #(
    parameter int W = 35
) (
    input  wire logic         clk,   // System clock.
    input  wire logic         rst_n, // Asynchronous reset, active low.
    input  wire logic [W-1:0] d,     // Raw pin levels.
    output logic      [W-1:0] q      // Levels safe to use in the clock domain.
);
    // The first stage feeds only the second one, never any logic.
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } epi_sync_type;
    epi_sync_type st_r;   // Registered state.
    epi_sync_type st_nxt; // Next state.

    ////////////////////////////////////////////////////////////////
    // Shift the levels one stage each edge.
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    // Both stages start low after reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;
endmodule
`default_nettype wire

// File: src/epi_top.sv
// External pin interrupt controller with an APB register slave.
//
// How it works
// - Unmasked toggle in a group raises its request.
// - Triggers work whatever the pin direction is.
// - Pin changes are seen while the I/O clock stops.
// - Pin-change flags set only with I/O clock.
// - Pin back to original before wake: no flag.
// - Sense field picks low, any, falling, rising.
// - Level mode requests while the pin stays low.
// - Dedicated pin detection also works in deep sleep.
// - Dedicated request needs mask bit and global enable.
// - Dedicated flag sets on trigger, clears on ack/one.
// - Level mode keeps the dedicated flag cleared.
// - Sleep blocks disabled pin buffer; may set flag.
// - Groups 3 and 2 need enable and global bit.
// - Four mask bytes choose the contributing pins.
// - Sense register bits 7:6 read as zero.
// - Groups 1 and 0 need enable and global bit.
// - Group flag sets on change, clears on ack/one.
// - Pin mask bytes reset to zero, fully writable.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "epi_consts.svh"
module epi_top (
    input  wire logic                SYS_CLK,           // System clock, 50 MHz.
    input  wire logic                RST_N,             // Asynchronous reset, active low.
    input  wire logic                PSEL,              // APB select.
    input  wire logic                PENABLE,           // APB access phase.
    input  wire logic                PWRITE,            // APB direction, high for write.
    input  wire logic [11:0]         PADDR,             // APB byte address.
    input  wire logic [31:0]         PWDATA,            // APB write data.
    output logic      [31:0]         PRDATA,            // APB read data.
    output logic                     PREADY,            // APB transfer done.
    output logic                     PSLVERR,           // APB error on unmapped address.
    input  wire logic                GIE,               // Global enable bit of the core.
    input  wire epi_pkg::epi_ext_type EXT_ACK,          // Core ran a dedicated handler.
    input  wire epi_pkg::epi_grp_type PC_ACK,           // Core ran a group handler.
    input  wire logic                SLEEP_DEEP,        // Core sleeps deeper than idle.
    input  wire logic                IO_CLK_RUN,        // I/O clock is running.
    input  wire epi_pkg::epi_ext_type DEDICATED_IRQ_PINS, // Dedicated pin levels.
    input  wire logic [31:0]         PIN_CHANGE_INPUTS, // Pin-change pin levels.
    output epi_pkg::epi_ext_type     EXT_IRQ,           // Dedicated requests to the core.
    output epi_pkg::epi_grp_type     PC_IRQ,            // Group requests to the core.
    output logic                     WAKE               // Wake request to the sleep logic.
);
    import epi_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Declarations.
    epi_state_type          st_r;     // Registered state.
    epi_state_type          st_nxt;   // Next state.
    logic [34:0]            sync_q;   // Synchronised pins.
    logic [`EPI_N_EXT-1:0]  ext_s;    // Synchronised dedicated pins.
    logic [`EPI_N_PC-1:0]   pc_s;     // Synchronised pin-change pins.
    logic [`EPI_N_EXT-1:0]  ext_in;   // Dedicated pins after the input buffer.
    logic [`EPI_N_EXT-1:0]  lvl_mode; // Pin is in low-level mode.
    logic [`EPI_N_EXT-1:0]  ext_trig; // Edge trigger seen this cycle.
    logic [`EPI_N_GRP-1:0]  pc_hit;   // Group has an unmasked change.
    logic [`EPI_IW-1:0]     idx;      // Register index of the access.
    logic                   hit;      // Address is mapped.
    logic [31:0]            rd_word;  // Read data for the address.
    logic                   wr;       // Write takes effect this edge.

    ////////////////////////////////////////////////////////////////
    // Synchronise every pin before it may set a flag.
    epi_sync #(
        .W (35)
    ) u_sync (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .d     ({DEDICATED_IRQ_PINS, PIN_CHANGE_INPUTS}),
        .q     (sync_q)
    );
    assign ext_s = sync_q[34:32];
    assign pc_s  = sync_q[31:0];

    ////////////////////////////////////////////////////////////////
    // Per dedicated pin: input buffer gating and the sense decoder.
    // The pin level is used whatever its direction, so driving it
    // from the core gives a software interrupt.
    genvar n;
    generate
        for (n = 0; n < `EPI_N_EXT; n++) begin : g_ext
            epi_sense_type sns; // Decoded sense field.
            assign sns = epi_sense_type'(st_r.sense[2*n +: 2]);
            // A disabled pin loses its buffer in sleep and reads low.
            assign ext_in[n] = ext_s[n] & ~(SLEEP_DEEP & ~st_r.ext_mask[n]);
            assign lvl_mode[n] = (sns == EPI_SNS_LOW);
            // Edges are found on the free-running system clock.
            assign ext_trig[n] =
                ((sns == EPI_SNS_ANY)  & (ext_in[n] ^ st_r.ext_prev[n])) |
                ((sns == EPI_SNS_FALL) & st_r.ext_prev[n] & ~ext_in[n]) |
                ((sns == EPI_SNS_RISE) & ~st_r.ext_prev[n] & ext_in[n]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // Per group: compare the pins with the reference taken while the
    // I/O clock last ran, through the pin mask byte.
    genvar g;
    generate
        for (g = 0; g < `EPI_N_GRP; g++) begin : g_grp
            assign pc_hit[g] = |((pc_s[`EPI_GRP_W*g +: `EPI_GRP_W] ^
                                  st_r.pc_ref[`EPI_GRP_W*g +: `EPI_GRP_W]) &
                                 st_r.pc_mask[`EPI_GRP_W*g +: `EPI_GRP_W]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // Address decode and read data.
    assign idx = PADDR[`EPI_AW-1:2];

    always_comb begin
        hit     = 1'b1;
        rd_word = `EPI_RST_WORD;
        case (idx)
            `EPI_IDX_EXT_MSK: begin
                rd_word[2:0] = st_r.ext_mask;
            end
            `EPI_IDX_SENSE: begin
                // Upper two bits stay zero in the word.
                rd_word[5:0] = st_r.sense;
            end
            `EPI_IDX_EXT_FLG: begin
                rd_word[2:0] = st_r.ext_flag;
            end
            `EPI_IDX_PC_EN: begin
                rd_word[3:0] = st_r.pc_en;
            end
            `EPI_IDX_PC_FLG: begin
                rd_word[3:0] = st_r.pc_flag;
            end
            `EPI_IDX_PC_MSK0: begin
                rd_word[7:0] = st_r.pc_mask[7:0];
            end
            `EPI_IDX_PC_MSK1: begin
                rd_word[7:0] = st_r.pc_mask[15:8];
            end
            `EPI_IDX_PC_MSK2: begin
                rd_word[7:0] = st_r.pc_mask[23:16];
            end
            `EPI_IDX_PC_MSK3: begin
                rd_word[7:0] = st_r.pc_mask[31:24];
            end
            default: begin
                // Unmapped words read zero and report an error.
                hit = 1'b0;
            end
        endcase
    end

    // A write lands at the edge that completes the access phase.
    assign wr = PSEL & PENABLE & st_r.pready & PWRITE & hit;

    ////////////////////////////////////////////////////////////////
    // Next state: bus answer, registers, flags and requests.
    always_comb begin
        st_nxt = st_r;
        // The answer comes at the first access edge, no wait states.
        st_nxt.pready  = PSEL & ~PENABLE;
        st_nxt.pslverr = PSEL & ~PENABLE & ~hit;
        st_nxt.prdata  = (PSEL & ~PENABLE & ~PWRITE) ? rd_word : `EPI_RST_WORD;

        // Plain register writes.
        if (wr) begin
            case (idx)
                `EPI_IDX_EXT_MSK: begin
                    st_nxt.ext_mask = PWDATA[2:0];
                end
                `EPI_IDX_SENSE: begin
                    st_nxt.sense = PWDATA[5:0];
                end
                `EPI_IDX_PC_EN: begin
                    st_nxt.pc_en = PWDATA[3:0];
                end
                `EPI_IDX_PC_MSK0: begin
                    st_nxt.pc_mask[7:0] = PWDATA[7:0];
                end
                `EPI_IDX_PC_MSK1: begin
                    st_nxt.pc_mask[15:8] = PWDATA[7:0];
                end
                `EPI_IDX_PC_MSK2: begin
                    st_nxt.pc_mask[23:16] = PWDATA[7:0];
                end
                `EPI_IDX_PC_MSK3: begin
                    st_nxt.pc_mask[31:24] = PWDATA[7:0];
                end
                default: begin
                    // Flag words are handled below.
                end
            endcase
        end

        // Dedicated flags: a handler ack or a written one clears, a
        // trigger in the same cycle wins, level mode forces zero.
        st_nxt.ext_flag = ((st_r.ext_flag &
                            ~(EXT_ACK | ((wr && idx == `EPI_IDX_EXT_FLG) ?
                                         PWDATA[2:0] : `EPI_RST_EXT))) |
                           ext_trig) & ~lvl_mode;
        st_nxt.ext_prev = ext_in;

        // Group flags set only while the I/O clock runs; the
        // reference freezes without it so a pin that toggles back
        // before wake leaves no flag behind.
        st_nxt.pc_flag = (st_r.pc_flag &
                          ~(PC_ACK | ((wr && idx == `EPI_IDX_PC_FLG) ?
                                      PWDATA[3:0] : `EPI_RST_GRP))) |
                         (pc_hit & {`EPI_N_GRP{IO_CLK_RUN}});
        if (IO_CLK_RUN) begin
            st_nxt.pc_ref = pc_s;
        end

        // Requests to the core need the mask bit or group enable bit and the global enable.
        st_nxt.ext_irq = st_r.ext_mask & {`EPI_N_EXT{GIE}} &
                         ((lvl_mode & ~ext_in) |
                          (~lvl_mode & st_r.ext_flag));
        st_nxt.pc_irq  = st_r.pc_en & st_r.pc_flag &
                         {`EPI_N_GRP{GIE}};

        // Wake comes straight from the pins, not from the flags.
        st_nxt.wake = SLEEP_DEEP & GIE &
                      (|(st_r.ext_mask & ((lvl_mode & ~ext_in) | ext_trig)) |
                       |(st_r.pc_en & pc_hit));
    end

    ////////////////////////////////////////////////////////////////
    // State register; every register resets to zero.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_r          <= '0;
            st_r.ext_mask <= `EPI_RST_EXT;
            st_r.sense    <= `EPI_RST_SENSE;
            st_r.pc_en    <= `EPI_RST_GRP;
            st_r.pc_mask  <= `EPI_RST_PC_MSK;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Every output is a flip-flop.
    assign PRDATA  = st_r.prdata;
    assign PREADY  = st_r.pready;
    assign PSLVERR = st_r.pslverr;
    assign EXT_IRQ = st_r.ext_irq;
    assign PC_IRQ  = st_r.pc_irq;
    assign WAKE    = st_r.wake;

    ////////////////////////////////////////////////////////////////
    // Checks.
    // All but a_sleep_gate and a_sense_rsvd watch the registered state one edge after its cause, so a
    // failure names the cycle in which the next-state logic went wrong.
    // All of them sit in the system clock domain and sleep while reset.
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    a_pc_flag_set: assert property (
        (IO_CLK_RUN && pc_hit != 4'h0) |=>
        ((st_r.pc_flag & $past(pc_hit)) == $past(pc_hit)))
        else $error("Group flag missed a pin change.");

    a_pc_no_io_set: assert property (
        !IO_CLK_RUN |=> ((st_r.pc_flag & ~$past(st_r.pc_flag)) == 4'h0))
        else $error("Group flag set without the I/O clock.");

    a_pc_ref_freeze: assert property (
        !IO_CLK_RUN |=> (st_r.pc_ref == $past(st_r.pc_ref)))
        else $error("Pin reference moved while the I/O clock stood.");

    a_lvl_request: assert property (
        (GIE && (lvl_mode & ~ext_in & st_r.ext_mask) != 3'h0) |=>
        ((EXT_IRQ & $past(lvl_mode & ~ext_in & st_r.ext_mask)) ==
         $past(lvl_mode & ~ext_in & st_r.ext_mask)))
        else $error("Low level did not request.");

    a_lvl_flag_clr: assert property (
        (lvl_mode != 3'h0) |=> ((st_r.ext_flag & $past(lvl_mode)) == 3'h0))
        else $error("Flag set in level mode.");

    a_edge_flag_set: assert property (
        (ext_trig != 3'h0) |=>
        ((st_r.ext_flag & $past(ext_trig)) == $past(ext_trig)))
        else $error("Edge trigger did not set its flag.");

    a_gie_gates: assert property (
        !GIE |=> (EXT_IRQ == 3'h0 && PC_IRQ == 4'h0))
        else $error("Request without global enable.");

    a_group_request: assert property (
        (GIE && (st_r.pc_en & st_r.pc_flag) != 4'h0) |=> (PC_IRQ != 4'h0))
        else $error("Enabled group flag raised no request.");

    // A masked pin must never raise a group flag on its own.
    a_pc_no_spur: assert property (
        (pc_hit == 4'h0) |=> ((st_r.pc_flag & ~$past(st_r.pc_flag)) == 4'h0))
        else $error("Group flag set with no unmasked change.");

    // In deep sleep a disabled dedicated pin reads low internally.
    a_sleep_gate: assert property (
        SLEEP_DEEP |-> ((ext_in & ~st_r.ext_mask) == 3'h0))
        else $error("Disabled pin buffer open in deep sleep.");

    a_sense_rsvd: assert property (
        (PSEL && PENABLE && PREADY && !PWRITE && idx == `EPI_IDX_SENSE) |->
        (PRDATA[7:6] == 2'b00))
        else $error("Reserved sense bits read as one.");

    a_apb_answer: assert property (
        (PSEL && !PENABLE) |=> PREADY ##1 !PREADY)
        else $error("APB answer not on the first access edge.");

    c_pc_request: cover property (GIE && PC_IRQ != 4'h0);
    c_lvl_request: cover property (EXT_IRQ != 3'h0 && lvl_mode != 3'h0);
    c_wake: cover property (SLEEP_DEEP && WAKE);
    c_unmapped: cover property (PREADY && PSLVERR);
    c_edge_flag: cover property (ext_trig != 3'h0 && st_r.ext_mask != 3'h0);
endmodule
`default_nettype wire

// File: verification/epi_core_model.sv
// Behavioural model of the processor core that enters the interrupt handlers.
`timescale 1ns/1ps
`default_nettype none
module epi_core_model (
    input  wire logic       clk,     // System clock.
    input  wire logic       rst_n,   // Asynchronous reset, active low.
    input  wire logic       ack_en,  // Handlers may be entered.
    input  wire logic       slow,    // Handler entry is delayed.
    input  wire logic [2:0] ext_irq, // Dedicated pin requests.
    input  wire logic [3:0] grp_irq, // Pin-change group requests.
    output logic      [2:0] ext_ack, // Dedicated handler entered, one cycle.
    output logic      [3:0] grp_ack  // Group handler entered, one cycle.
);
    logic [6:0] busy_r; // Request served, waiting for it to drop.
    logic [2:0] wait_r; // Cycles that a pending request has waited.
    logic [6:0] req;    // All requests side by side.
    logic [6:0] take;   // Requests whose handler starts now.

    assign req = {grp_irq, ext_irq};
    // A slow core needs four cycles to enter a handler, as after a long instruction.
    // A request is served once, so a held level does not trigger a second entry.
    assign take = (ack_en && (!slow || wait_r == 3'h4)) ? (req & ~busy_r) : 7'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Handler entry pulses; they clear the matching flags in the block.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_ack <= 3'h0;
            grp_ack <= 4'h0;
            busy_r  <= 7'h00;
            wait_r  <= 3'h0;
        end else begin
            ext_ack <= take[2:0];
            grp_ack <= take[6:3];
            busy_r  <= (busy_r & req) | take;
            wait_r  <= ((|(req & ~busy_r)) && wait_r != 3'h4) ? wait_r + 3'h1 : 3'h0;
        end
    end
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking testbench of the external pin interrupt block.
`timescale 1ns/1ps
`default_nettype none
`include "epi_consts.svh"
module tb_top;
    import epi_pkg::*;
    logic        SYS_CLK;    // System clock, 50 MHz.
    logic        RST_N;      // Reset, active low.
    logic        PSEL;       // APB select.
    logic        PENABLE;    // APB access phase.
    logic        PWRITE;     // APB direction.
    logic [11:0] PADDR;      // APB byte address.
    logic [31:0] PWDATA;     // APB write data.
    logic [31:0] PRDATA;     // APB read data.
    logic        PREADY;     // APB done.
    logic        PSLVERR;    // APB error.
    logic        GIE;        // Global enable of the core.
    epi_ext_type EXT_ACK;    // Dedicated handler entered.
    epi_grp_type PC_ACK;     // Group handler entered.
    logic        SLEEP_DEEP; // Deep sleep.
    logic        IO_CLK_RUN; // I/O clock running.
    epi_ext_type DED_PINS;   // Dedicated pin levels.
    logic [31:0] PC_PINS;    // Pin-change levels.
    epi_ext_type EXT_IRQ;    // Dedicated requests.
    epi_grp_type PC_IRQ;     // Group requests.
    logic        WAKE;       // Wake request.
    logic        ack_en;     // Core model may enter handlers.
    int          failures;   // Mismatches.
    int          checks;     // Comparisons.
    int          cycles;     // Clock cycles run.
    // Mask indices sit at 2..5, for groups 0..3.
    localparam logic [9:0] REG_IDX [8] = '{`EPI_IDX_EXT_MSK, `EPI_IDX_PC_EN,
        `EPI_IDX_PC_MSK0, `EPI_IDX_PC_MSK1, `EPI_IDX_PC_MSK2, `EPI_IDX_PC_MSK3,
        `EPI_IDX_SENSE, `EPI_IDX_EXT_FLG};

    epi_top epi_top_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .GIE(GIE), .EXT_ACK(EXT_ACK), .PC_ACK(PC_ACK),
        .SLEEP_DEEP(SLEEP_DEEP), .IO_CLK_RUN(IO_CLK_RUN), .DEDICATED_IRQ_PINS(DED_PINS),
        .PIN_CHANGE_INPUTS(PC_PINS), .EXT_IRQ(EXT_IRQ), .PC_IRQ(PC_IRQ), .WAKE(WAKE));
    epi_core_model epi_core_model_inst (.clk(SYS_CLK), .rst_n(RST_N), .ack_en(ack_en),
        .slow(1'b1), .ext_irq(EXT_IRQ), .grp_irq(PC_IRQ), .ext_ack(EXT_ACK), .grp_ack(PC_ACK));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and a cycle ceiling far above the several hundred cycles the run needs.
    initial begin
        SYS_CLK = 1'b0;
        forever #10 SYS_CLK = ~SYS_CLK;
    end
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (failures == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask
    // One APB transfer; the request holds until PREADY is seen high at an edge.
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge SYS_CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= wr;
        PADDR   <= {idx, 2'b00};
        PWDATA  <= wd;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        @(posedge SYS_CLK);
        // Only the bench's cycle ceiling ends a wait that never answers.
        while (PREADY !== 1'b1) begin
            @(posedge SYS_CLK);
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, idx, wd, rd, err);
    endtask
    task automatic rdc(input logic [9:0] idx, input logic [31:0] exp, input logic eerr = 1'b0);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, idx, 32'h0000_0000, rd, err);
        check(rd, exp);
        check(32'(err), 32'(eerr));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; pins are driven as an external source that holds its levels.
    initial begin
        int i;
        int n;
        RST_N = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 12'h000;
        PWDATA = 32'h0000_0000;
        GIE = 1'b0;
        SLEEP_DEEP = 1'b0;
        IO_CLK_RUN = 1'b1;
        DED_PINS = 3'h7;
        PC_PINS = 32'h0000_0000;
        ack_en = 1'b0;
        failures = 0;
        checks = 0;
        cycles = 0;
        wt(16);
        RST_N <= 1'b1;
        // Reset values, writable widths, reserved bits and an unmapped place.
        for (i = 0; i < 8; i++) rdc(REG_IDX[i], 32'h0000_0000);
        rdc(`EPI_IDX_PC_FLG, 32'h0000_0000);
        rdc(10'h3FF, 32'h0000_0000, 1'b1);
        for (i = 2; i < 6; i++) begin
            wr(REG_IDX[i], 32'hFFFF_FFFF);
            rdc(REG_IDX[i], 32'h0000_00FF);
            wr(REG_IDX[i], 32'h0000_0000);
        end
        wr(`EPI_IDX_SENSE, 32'hFFFF_FFFF);
        rdc(`EPI_IDX_SENSE, 32'h0000_003F);
        // Edge codes on all three pins, flags cleared by writing ones.
        for (i = 1; i < 4; i++) begin
            wr(`EPI_IDX_SENSE, i * 32'h0000_0015);
            wr(`EPI_IDX_EXT_FLG, 32'h0000_0007);
            @(posedge SYS_CLK) DED_PINS <= 3'h0;
            wt(6);
            rdc(`EPI_IDX_EXT_FLG, (i != 3) ? 32'h0000_0007 : 32'h0000_0000);
            wr(`EPI_IDX_EXT_FLG, 32'h0000_0007);
            rdc(`EPI_IDX_EXT_FLG, 32'h0000_0000);
            @(posedge SYS_CLK) DED_PINS <= 3'h7;
            wt(6);
            rdc(`EPI_IDX_EXT_FLG, (i != 2) ? 32'h0000_0007 : 32'h0000_0000);
        end
        // Low-level code: request while low, flag held clear, global gate.
        wr(`EPI_IDX_SENSE, 32'h0000_0000);
        wr(`EPI_IDX_EXT_FLG, 32'h0000_0007);
        wr(`EPI_IDX_EXT_MSK, 32'h0000_0007);
        GIE <= 1'b1;
        // The source holds the low level for many cycles and through a deep-sleep wake.
        @(posedge SYS_CLK) DED_PINS <= 3'h2;
        SLEEP_DEEP <= 1'b1;
        wt(26);
        check(32'(WAKE), 32'h0000_0001);
        SLEEP_DEEP <= 1'b0;
        check(32'(EXT_IRQ), 32'h0000_0005);
        rdc(`EPI_IDX_EXT_FLG, 32'h0000_0000);
        @(posedge SYS_CLK) GIE <= 1'b0;
        wt(4);
        check(32'(EXT_IRQ), 32'h0000_0000);
        // Falling edge served by a slow core; the edge passes the synchroniser first.
        wr(`EPI_IDX_EXT_MSK, 32'h0000_0000);
        @(posedge SYS_CLK) DED_PINS <= 3'h7;
        wr(`EPI_IDX_SENSE, 32'h0000_002A);
        wr(`EPI_IDX_EXT_FLG, 32'h0000_0007);
        wr(`EPI_IDX_EXT_MSK, 32'h0000_0001);
        GIE <= 1'b1;
        ack_en <= 1'b1;
        @(posedge SYS_CLK) DED_PINS <= 3'h6;
        wt(4);
        check(32'(EXT_IRQ), 32'h0000_0000);
        n = 0;
        while (EXT_ACK[0] !== 1'b1 && n < 30) begin
            @(posedge SYS_CLK);
            n++;
        end
        check(32'(n < 30), 32'h0000_0001);
        wt(4);
        check(32'(EXT_IRQ), 32'h0000_0000);
        rdc(`EPI_IDX_EXT_FLG, 32'h0000_0000);
        ack_en <= 1'b0;
        @(posedge SYS_CLK) DED_PINS <= 3'h7;
        // Disabled pins read low in deep sleep, which a falling-edge code sees.
        wr(`EPI_IDX_EXT_MSK, 32'h0000_0000);
        wr(`EPI_IDX_EXT_FLG, 32'h0000_0007);
        @(posedge SYS_CLK) SLEEP_DEEP <= 1'b1;
        wt(6);
        rdc(`EPI_IDX_EXT_FLG, 32'h0000_0007);
        @(posedge SYS_CLK) SLEEP_DEEP <= 1'b0;
        wt(6);
        // Each group: masked pin ignored, unmasked pin flags, global gate, clear.
        for (i = 0; i < 4; i++) begin
            wr(REG_IDX[2 + i], 32'h0000_0008);
            wr(`EPI_IDX_PC_EN, 32'h0000_0001 << i);
            wr(`EPI_IDX_PC_FLG, 32'h0000_000F);
            @(posedge SYS_CLK) PC_PINS <= PC_PINS ^ (32'h0000_0010 << (8 * i));
            wt(6);
            rdc(`EPI_IDX_PC_FLG, 32'h0000_0000);
            @(posedge SYS_CLK) PC_PINS <= PC_PINS ^ (32'h0000_0008 << (8 * i));
            wt(6);
            check(32'(PC_IRQ), 32'h0000_0001 << i);
            rdc(`EPI_IDX_PC_FLG, 32'h0000_0001 << i);
            @(posedge SYS_CLK) GIE <= 1'b0;
            wt(3);
            check(32'(PC_IRQ), 32'h0000_0000);
            GIE <= 1'b1;
            wr(`EPI_IDX_PC_FLG, 32'h0000_000F);
            wt(3);
            check(32'(PC_IRQ), 32'h0000_0000);
            wr(REG_IDX[2 + i], 32'h0000_0000);
        end
        // Deep sleep without I/O clock: wake, no flag, toggled-back pin gives nothing.
        wr(`EPI_IDX_PC_MSK0, 32'h0000_0008);
        wr(`EPI_IDX_PC_EN, 32'h0000_0001);
        for (i = 0; i < 2; i++) begin
            @(posedge SYS_CLK) SLEEP_DEEP <= 1'b1;
            IO_CLK_RUN <= 1'b0;
            @(posedge SYS_CLK) PC_PINS <= PC_PINS ^ 32'h0000_0008;
            wt(6);
            check(32'(WAKE), 32'h0000_0001);
            check(32'(PC_IRQ), 32'h0000_0000);
            if (i == 0) PC_PINS <= PC_PINS ^ 32'h0000_0008;
            wt(6);
            @(posedge SYS_CLK) IO_CLK_RUN <= 1'b1;
            SLEEP_DEEP <= 1'b0;
            wt(6);
            rdc(`EPI_IDX_PC_FLG, 32'(i));
        end
        // The core enters the group handler, which clears the flag.
        ack_en <= 1'b1;
        wt(20);
        check(32'(PC_IRQ), 32'h0000_0000);
        rdc(`EPI_IDX_PC_FLG, 32'h0000_0000);
        give_verdict();
    end
endmodule
`default_nettype wire
